//--- serial_dma_pkg.sv
package serial_dma_pkg;

    // ----------------------------------------------------------------
    // Serial frame and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 250_000_000;
    localparam int unsigned BIT_RATE   = 38_400;
    // Bit period in clocks; truncation gives under 0.01 % rate error
    localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE;
    localparam int unsigned DATA_BITS  = 8;
    localparam logic [2:0]  LAST_BIT   = 3'h7;
    localparam logic        LINE_IDLE  = 1'b1;
    localparam logic        START_BIT  = 1'b0;
    localparam logic        STOP_BIT   = 1'b1;

    // ----------------------------------------------------------------
    // Buffers and transfer length
    // ----------------------------------------------------------------
    localparam int unsigned BUF_DEPTH  = 256;
    localparam int unsigned LEN_W      = 9;
    localparam logic [8:0]  LEN_RST    = 9'h100;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W     = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_LEN    = 12'h004;
    localparam logic [11:0] REG_STAT   = 12'h008;
    localparam logic [1:0]  WIN_REG    = 2'h0;
    localparam logic [1:0]  WIN_TX     = 2'h1;
    localparam logic [1:0]  WIN_RX     = 2'h2;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CTRL_ARM       = 0;
    localparam int unsigned STAT_TX_BUSY   = 0;
    localparam int unsigned STAT_RX_BUSY   = 1;
    localparam int unsigned STAT_FERR      = 2;
    localparam int unsigned STAT_TXCNT_LSB = 8;
    localparam int unsigned STAT_RXCNT_LSB = 20;

    // ----------------------------------------------------------------
    // Bus carriers and engine state encodings
    // ----------------------------------------------------------------
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [11:0] adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef enum logic [3:0] {
        TX_IDLE  = 4'h1,
        TX_START = 4'h2,
        TX_DATA  = 4'h4,
        TX_STOP  = 4'h8
    } tx_state_t;

    typedef enum logic [3:0] {
        RX_IDLE  = 4'h1,
        RX_START = 4'h2,
        RX_DATA  = 4'h4,
        RX_STOP  = 4'h8
    } rx_state_t;

endpackage : serial_dma_pkg

//--- dma_fed_async_serial_port.sv
// Behaviour
// [R1] Transmit and receive both start only on a falling edge of the start pin.
// [R2] Asynchronous framing with start and stop bits, no shared clock.
// [R3] Line runs at 38,400 bits per second.
// [R4] Eight data bits per character, least significant bit first.
// [R5] Exactly one stop bit ends each character.
// [R6] No parity bit is sent, expected or checked.
// [R7] Transmission never waits on any flow control handshake.
// [R8] Engine moves each transmit byte from buffer into the transmitter unaided.
// [R9] Engine moves each received byte into the receive buffer.
// [R10] Line idles high; each frame opens with one low start bit.
//
// Design decisions made here: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module dma_fed_async_serial_port #(
    parameter int unsigned BIT_CYCLES = serial_dma_pkg::BIT_CYCLES,
    parameter int unsigned DEPTH      = serial_dma_pkg::BUF_DEPTH
) (
    // Clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // Register bus
    input  wire serial_dma_pkg::wb_req_t wb_req,
    output serial_dma_pkg::wb_rsp_t      wb_rsp,
    // Pins
    input  wire logic                    start_request_pin,
    input  wire logic                    rxd,
    output logic                         txd
);
    import serial_dma_pkg::*;

    localparam int IW = $clog2(DEPTH);
    localparam int CW = LEN_W;
    localparam int BW = $clog2(BIT_CYCLES);
    localparam logic [BW-1:0] BIT_END  = BW'(BIT_CYCLES - 1);
    localparam logic [BW-1:0] HALF_END = BW'(BIT_CYCLES / 2 - 1);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] start_sync;
    logic [2:0] rxd_sync;
    logic       start_lvl;
    logic       start_lvl_d;
    logic       rxd_lvl;
    logic       start_fall;

    // Change accepted only when the last two stages agree
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            start_sync  <= 3'h7;
            rxd_sync    <= 3'h7;
            start_lvl   <= 1'b1;
            start_lvl_d <= 1'b1;
            rxd_lvl     <= LINE_IDLE;
        end else begin
            start_sync  <= {start_sync[1:0], start_request_pin};
            rxd_sync    <= {rxd_sync[1:0], rxd};
            start_lvl_d <= start_lvl;
            if (start_sync[2] == start_sync[1]) begin
                start_lvl <= start_sync[2];
            end
            if (rxd_sync[2] == rxd_sync[1]) begin
                rxd_lvl <= rxd_sync[2];
            end
        end
    end

    assign start_fall = start_lvl_d & ~start_lvl; // R1

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic            arm;
    logic [CW-1:0]   xfer_len;
    logic            frame_err;
    logic [7:0]      tx_mem [DEPTH];
    logic [7:0]      rx_mem [DEPTH];

    tx_state_t       tx_state;
    logic [BW-1:0]   tx_baud;
    logic [2:0]      tx_bitn;
    logic [7:0]      tx_shift;
    logic            tx_active;
    logic [CW-1:0]   tx_count;

    rx_state_t       rx_state;
    logic [BW-1:0]   rx_baud;
    logic [2:0]      rx_bitn;
    logic [7:0]      rx_shift;
    logic            rx_active;
    logic [CW-1:0]   rx_count;

    logic            run_go;
    logic            rx_frame_evt;
    logic            bus_hit;
    logic            bus_wr;
    logic [1:0]      bus_win;
    logic [IW-1:0]   bus_idx;
    logic [31:0]     rd_data;

    // Busy ends ignore further start edges until both sides finish
    assign run_go = start_fall & arm & ~tx_active & ~rx_active; // R1

    // ----------------------------------------------------------------
    // Transmitter and its feed
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tx_state  <= TX_IDLE;
            txd       <= LINE_IDLE;
            tx_baud   <= '0;
            tx_bitn   <= '0;
            tx_shift  <= '0;
            tx_active <= 1'b0;
            tx_count  <= '0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    txd <= LINE_IDLE; // R10
                    if (run_go) begin
                        tx_active <= 1'b1; // R1
                        tx_count  <= '0;
                    end else if (tx_active) begin
                        if (tx_count >= xfer_len) begin
                            tx_active <= 1'b0;
                        end else begin
                            // No handshake input gates the next byte
                            tx_shift <= tx_mem[tx_count[IW-1:0]]; // R8 R7
                            tx_count <= tx_count + CW'(1);
                            txd      <= START_BIT; // R10 R2
                            tx_baud  <= '0;
                            tx_state <= TX_START;
                        end
                    end
                end
                TX_START: begin
                    if (tx_baud == BIT_END) begin // R3
                        tx_baud  <= '0;
                        tx_bitn  <= '0;
                        txd      <= tx_shift[0]; // R4
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        tx_state <= TX_DATA;
                    end else begin
                        tx_baud <= tx_baud + BW'(1);
                    end
                end
                TX_DATA: begin
                    if (tx_baud == BIT_END) begin
                        tx_baud <= '0;
                        if (tx_bitn == LAST_BIT) begin
                            // Stop follows data directly: no parity slot
                            txd      <= STOP_BIT; // R5 R6
                            tx_state <= TX_STOP;
                        end else begin
                            txd      <= tx_shift[0]; // R4
                            tx_shift <= {1'b0, tx_shift[7:1]};
                            tx_bitn  <= tx_bitn + 3'h1;
                        end
                    end else begin
                        tx_baud <= tx_baud + BW'(1);
                    end
                end
                TX_STOP: begin
                    if (tx_baud == BIT_END) begin
                        tx_baud  <= '0;
                        tx_state <= TX_IDLE; // R5
                    end else begin
                        tx_baud <= tx_baud + BW'(1);
                    end
                end
                default: begin
                    txd      <= LINE_IDLE;
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receiver and its drain
    // ----------------------------------------------------------------
    assign rx_frame_evt = (rx_state == RX_STOP) && (rx_baud == BIT_END)
                          && (rxd_lvl != STOP_BIT);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_state  <= RX_IDLE;
            rx_baud   <= '0;
            rx_bitn   <= '0;
            rx_shift  <= '0;
            rx_active <= 1'b0;
            rx_count  <= '0;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    rx_baud <= '0;
                    if (run_go) begin
                        rx_active <= 1'b1; // R1
                        rx_count  <= '0;
                    end else if (rx_active) begin
                        if (rx_count >= xfer_len) begin
                            rx_active <= 1'b0;
                        end else if (rxd_lvl == START_BIT) begin
                            rx_state <= RX_START; // R10
                        end
                    end
                end
                RX_START: begin
                    // Recheck at mid bit so a short glitch is not a frame
                    if (rx_baud == HALF_END) begin
                        rx_baud <= '0;
                        rx_bitn <= '0;
                        if (rxd_lvl == START_BIT) begin
                            rx_state <= RX_DATA; // R2
                        end else begin
                            rx_state <= RX_IDLE;
                        end
                    end else begin
                        rx_baud <= rx_baud + BW'(1);
                    end
                end
                RX_DATA: begin
                    if (rx_baud == BIT_END) begin // R3
                        rx_baud  <= '0;
                        rx_shift <= {rxd_lvl, rx_shift[7:1]}; // R4
                        if (rx_bitn == LAST_BIT) begin
                            rx_state <= RX_STOP; // R6
                        end else begin
                            rx_bitn <= rx_bitn + 3'h1;
                        end
                    end else begin
                        rx_baud <= rx_baud + BW'(1);
                    end
                end
                RX_STOP: begin
                    // Byte is kept even on a bad stop bit; error flag tells
                    if (rx_baud == BIT_END) begin // R5
                        rx_baud  <= '0;
                        rx_count <= rx_count + CW'(1); // R9
                        rx_state <= RX_IDLE;
                    end else begin
                        rx_baud <= rx_baud + BW'(1);
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer write, no reset on storage
    always_ff @(posedge sys_clk) begin
        if ((rx_state == RX_STOP) && (rx_baud == BIT_END)) begin
            rx_mem[rx_count[IW-1:0]] <= rx_shift; // R9
        end
    end

    // ----------------------------------------------------------------
    // Wishbone slave
    // ----------------------------------------------------------------
    assign bus_hit = wb_req.cyc & wb_req.stb & ~wb_rsp.ack;
    assign bus_wr  = bus_hit & wb_req.we;
    assign bus_win = wb_req.adr[ADDR_W-1 -: $bits(bus_win)];
    assign bus_idx = wb_req.adr[IW+1:2];

    always_comb begin
        rd_data = '0;
        case (bus_win)
            WIN_REG: begin
                if (wb_req.adr == REG_CTRL) begin
                    rd_data[CTRL_ARM] = arm;
                end else if (wb_req.adr == REG_LEN) begin
                    rd_data[CW-1:0] = xfer_len;
                end else if (wb_req.adr == REG_STAT) begin
                    rd_data[STAT_TX_BUSY]            = tx_active;
                    rd_data[STAT_RX_BUSY]            = rx_active;
                    rd_data[STAT_FERR]               = frame_err;
                    rd_data[STAT_TXCNT_LSB +: CW]    = tx_count;
                    rd_data[STAT_RXCNT_LSB +: CW]    = rx_count;
                end
            end
            WIN_TX:  rd_data[7:0] = tx_mem[bus_idx];
            WIN_RX:  rd_data[7:0] = rx_mem[bus_idx];
            default: rd_data = '0;
        endcase
    end

    // Every access is answered one edge later; unmapped reads give zero
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wb_rsp   <= '0;
            arm      <= 1'b0;
            xfer_len <= LEN_RST;
        end else begin
            wb_rsp.ack <= bus_hit;
            wb_rsp.dat <= rd_data;
            if (bus_wr && wb_req.sel[0] && (wb_req.adr == REG_CTRL)) begin
                arm <= wb_req.dat[CTRL_ARM];
            end
            if (bus_wr && wb_req.sel[0] && (wb_req.adr == REG_LEN)) begin
                xfer_len <= wb_req.dat[CW-1:0];
            end
        end
    end

    // Framing error: a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            frame_err <= 1'b0;
        end else if (rx_frame_evt) begin
            frame_err <= 1'b1;
        end else if (bus_wr && wb_req.sel[0] && (wb_req.adr == REG_STAT)
                     && wb_req.dat[STAT_FERR]) begin
            frame_err <= 1'b0;
        end
    end

    // Transmit buffer load
    always_ff @(posedge sys_clk) begin
        if (bus_wr && wb_req.sel[0] && (bus_win == WIN_TX)) begin
            tx_mem[bus_idx] <= wb_req.dat[7:0];
        end
    end

endmodule : dma_fed_async_serial_port

//--- serial_port_checker_assertions.sv
`timescale 1ns/1ps
module serial_port_checker #(
    parameter int unsigned BIT_CYCLES = 16
) (
    // Clock and reset
    input wire logic                    sys_clk,
    input wire logic                    srst,
    // Watched ports
    input wire serial_dma_pkg::wb_req_t wb_req,
    input wire serial_dma_pkg::wb_rsp_t wb_rsp,
    input wire logic                    start_request_pin,
    input wire logic                    rxd,
    input wire logic                    txd
);
    import serial_dma_pkg::*;
    logic        txd_q;
    logic        pin_q;
    logic        in_frame;
    int unsigned run_len;
    int unsigned fcnt;
    int unsigned since_fall;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Length of the current constant stretch of the line
    always_ff @(posedge sys_clk) begin
        txd_q   <= srst ? 1'b1 : txd;
        run_len <= (srst || txd != txd_q) ? 1 : run_len + 1;
    end
    // Saturating age of the last start pin fall
    always_ff @(posedge sys_clk) begin
        pin_q      <= start_request_pin;
        since_fall <= srst ? 255 : (pin_q && !start_request_pin) ? 0
                    : (since_fall < 255) ? since_fall + 1 : since_fall;
    end
    // Clock count inside a transmitted frame
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_frame <= 1'b0;
            fcnt     <= 0;
        end else if (!in_frame && txd_q && !txd) begin
            in_frame <= 1'b1;
            fcnt     <= 1;
        end else if (in_frame) begin
            in_frame <= (fcnt != 10 * BIT_CYCLES - 1);
            fcnt     <= fcnt + 1;
        end
    end

    sequence bus_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    // A long high stretch before a fall marks the first frame of a run
    sequence run_begin;
        $fell(txd) && run_len > 10 * BIT_CYCLES;
    endsequence
    sequence low_end;
        $rose(txd);
    endsequence

    reset_idle_a: assert property ($fell(srst) |-> txd && !wb_rsp.ack)
        else $error("line not idle after reset");
    start_low_a: assert property (in_frame && fcnt < BIT_CYCLES |-> !txd)
        else $error("start bit too short");
    stop_high_a: assert property (in_frame && fcnt >= 9 * BIT_CYCLES |-> txd)
        else $error("stop bit missing");
    bit_edge_a: assert property (in_frame && txd != txd_q |-> fcnt % BIT_CYCLES == 0)
        else $error("line changed inside a bit");
    low_run_a: assert property (low_end |-> run_len % BIT_CYCLES == 0)
        else $error("low stretch not whole bits");
    low_max_a: assert property (low_end |-> run_len <= 9 * BIT_CYCLES)
        else $error("low stretch too long");
    run_start_a: assert property (run_begin |-> since_fall inside {[3:12]})
        else $error("run began without a pin fall");
    ack_next_a: assert property (bus_take |=> wb_rsp.ack)
        else $error("no ack one cycle after request");
    ack_single_a: assert property (wb_rsp.ack |=> !wb_rsp.ack)
        else $error("ack longer than one cycle");
    ack_cause_a: assert property ($rose(wb_rsp.ack) |-> $past(wb_req.stb))
        else $error("ack without request");
endmodule : serial_port_checker

bind dma_fed_async_serial_port serial_port_checker #(.BIT_CYCLES(BIT_CYCLES)) port_chk (
    .sys_clk(sys_clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .start_request_pin(start_request_pin), .rxd(rxd), .txd(txd));

//--- serial_terminal_model.sv
`timescale 1ns/1ps
module serial_terminal_model #(
    parameter int unsigned BIT_CYCLES = 16
) (
    // Clock
    input  wire logic sys_clk,
    // Serial lines
    input  wire logic txd,
    output logic      rxd,
    // Scenario controls
    input  wire logic slow,
    input  wire logic bad_stop
);
    logic [7:0] got[$];
    logic [7:0] b;
    logic [9:0] f;
    int         pending = 0;
    int         sent    = 0;

    initial rxd = 1'b1;
    // Mid-bit sampling tolerates the block's own rate error
    always begin
        @(negedge txd);
        repeat (BIT_CYCLES / 2) @(posedge sys_clk);
        if (txd === 1'b0) begin
            pending++;
            for (int i = 0; i < 8; i++) begin
                repeat (BIT_CYCLES) @(posedge sys_clk);
                b[i] = txd;
            end
            repeat (BIT_CYCLES) @(posedge sys_clk);
            if (txd === 1'b1) got.push_back(b);
        end
    end
    // One reply per frame heard, never gated by a handshake
    always begin
        wait (pending > 0);
        pending--;
        if (slow) repeat (3 * BIT_CYCLES) @(posedge sys_clk);
        @(posedge sys_clk);
        f = {~bad_stop, 8'(8'h5a + sent * 37), 1'b0};
        sent++;
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT_CYCLES) @(posedge sys_clk);
        end
        rxd <= 1'b1;
    end
endmodule : serial_terminal_model

//--- dma_fed_async_serial_port_bench.sv
`timescale 1ns/1ps
module dma_fed_async_serial_port_bench;
    import serial_dma_pkg::*;
    localparam int unsigned BITS = 16;
    logic        sys_clk     = 1'b0;
    logic        srst        = 1'b1;
    wb_req_t     wb_req      = '0;
    wb_rsp_t     wb_rsp;
    logic        pin         = 1'b1;
    logic        rxd;
    logic        txd;
    logic        slow        = 1'b0;
    logic        bad_stop    = 1'b0;
    logic [31:0] rd;
    int          fail_count  = 0;
    int          check_count = 0;
    int          reply_idx   = 0;
    logic [7:0]  tx_pat[4]   = '{8'h01, 8'h80, 8'ha5, 8'h3c};

    always #2 sys_clk = ~sys_clk;

    dma_fed_async_serial_port #(.BIT_CYCLES(BITS)) DUT (
        .sys_clk(sys_clk), .srst(srst), .wb_req(wb_req), .wb_rsp(wb_rsp),
        .start_request_pin(pin), .rxd(rxd), .txd(txd));
    serial_terminal_model #(.BIT_CYCLES(BITS)) term (
        .sys_clk(sys_clk), .txd(txd), .rxd(rxd), .slow(slow), .bad_stop(bad_stop));

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One classic cycle; the answer time is never assumed
    task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wd};
        // Ack and data are taken at the rising edge that sees ack high
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        if (n >= 20) begin
            fail_count++;
            give_verdict();
        end
        rd = wb_rsp.dat;
        wb_req <= '0;
    endtask : wb

    // Idle line, reset values and the unmapped window after reset
    task automatic reset_and_map();
        @(negedge sys_clk);
        check({31'h0, txd}, 32'h1);
        wb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h0);
        wb(1'b0, REG_LEN, 32'h0);
        check(rd, 32'h100);
        wb(1'b1, REG_STAT, 32'hffff_fffb);
        wb(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, 12'hffc, 32'hffff_ffff);
        wb(1'b0, 12'hffc, 32'h0);
        check(rd, 32'h0);
    endtask : reset_and_map

    // Write one clears the error flag; counts and the arm bit stay
    task automatic clear_error();
        wb(1'b1, REG_STAT, 32'h4);
        wb(1'b0, REG_STAT, 32'h0);
        check(rd, 32'h0010_0100);
        wb(1'b0, REG_CTRL, 32'h0);
        check(rd, 32'h1);
    endtask : clear_error

    // A rise alone must not start a run; the fall must, when armed
    task automatic pulse(input logic armed);
        int n;
        pin <= 1'b1;
        repeat (7) @(posedge sys_clk);
        @(negedge sys_clk);
        check({31'h0, txd}, 32'h1);
        @(posedge sys_clk);
        pin <= 1'b0;
        n = 0;
        while (txd === 1'b1 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        check({31'h0, txd}, {31'h0, ~armed});
    endtask : pulse

    task automatic run_transfer(input int len, input logic ferr);
        int n;
        for (int i = 0; i < len; i++) wb(1'b1, 12'h400 + 12'(4 * i), {24'h0, tx_pat[i]});
        wb(1'b1, REG_LEN, 32'(len));
        wb(1'b1, REG_CTRL, 32'h1);
        term.got.delete();
        pulse(1'b1);
        n = 0;
        do begin
            wb(1'b0, REG_STAT, 32'h0);
            n++;
        end while (rd[1:0] !== 2'h0 && n < 3000);
        if (n >= 3000) begin
            fail_count++;
            give_verdict();
        end
        check(rd, {3'h0, 9'(len), 3'h0, 9'(len), 5'h0, ferr, 2'h0});
        check(32'(term.got.size()), 32'(len));
        for (int i = 0; i < term.got.size(); i++) begin
            check({24'h0, term.got[i]}, {24'h0, tx_pat[i]});
        end
        for (int i = 0; i < len; i++) begin
            wb(1'b0, 12'h800 + 12'(4 * i), 32'h0);
            check(rd, {24'h0, 8'(8'h5a + (reply_idx + i) * 37)});
        end
        reply_idx += len;
    endtask : run_transfer

    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        reset_and_map();
        pulse(1'b0);
        run_transfer(4, 1'b0);
        slow <= 1'b1;
        run_transfer(4, 1'b0);
        slow <= 1'b0;
        bad_stop <= 1'b1;
        run_transfer(1, 1'b1);
        bad_stop <= 1'b0;
        clear_error();
        give_verdict();
    end
endmodule : dma_fed_async_serial_port_bench
